// ---- rtl/prom_loader_map.svh ----
// register map, field positions, reset values and timing counts of the prom loader
// Notes on behaviour
// RULE1: select=1 fetch reads prom word at pointer[5:0] into scratch register.
// RULE2: select=1 save writes scratch register to prom word at pointer[5:0].
// RULE3: software sets fetch or save bit, then polls until it reads low.
// RULE4: while a prom access runs, control reads show fetch and save high.
// RULE5: other register accesses wait until done; both request bits clear at completion.
// RULE6: busy reporting and blocking also cover the load after reset.
// RULE7: with the attach strap low the prom is never accessed.
// RULE8: without prom, setup, base and station registers keep reset defaults.
// RULE9: without prom, software programs setup, base and station registers itself.
// RULE10: setup at word slot*4, base at slot*4+1; station at 20h-22h.
// RULE11: select=0 load fills setup, base, station; save writes setup and base.
// RULE12: slot straps all ones load only the station words.
// RULE13: prom is 64 words of 16 bits, word addressed, whole words only.
// RULE14: select, fetch and save are control bits 0-2, never stored in prom.
// RULE15: serial read, write-enable and write frames; save waits for ready.
// RULE16: requests written during an active operation are ignored.
`ifndef PROM_LOADER_MAP_SVH
`define PROM_LOADER_MAP_SVH

// ----------------------------------------------------------------
// register byte offsets
// ----------------------------------------------------------------
`define REG_CONTROL    8'h00
`define REG_POINTER    8'h04
`define REG_SCRATCH    8'h08
`define REG_SETUP      8'h0C
`define REG_BASE       8'h10
`define REG_STATION0   8'h14
`define REG_STATION1   8'h18
`define REG_STATION2   8'h1C
`define REG_STATUS     8'h20

// ----------------------------------------------------------------
// fields and reset values
// ----------------------------------------------------------------
`define CTL_SELECT_BIT 0
`define CTL_FETCH_BIT  1
`define CTL_SAVE_BIT   2
`define SETUP_RST      16'h0000
`define BASE_RST       16'h0000
`define STATION_RST    16'h0000
`define SLOT_NONE      3'h7
`define STATION_WORD   6'h20
`define STATION_LAST   3'h4

// ----------------------------------------------------------------
// serial frames and timing
// ----------------------------------------------------------------
`define FRAME_READ     3'h6
`define FRAME_WRITE    3'h5
`define FRAME_WEN      9'h130
`define CORE_CLK_MHZ   200
`define SK_HALF_NS     500
`define SK_HALF_CYC    ((`SK_HALF_NS * `CORE_CLK_MHZ + 999) / 1000)

`endif

// ---- rtl/prom_loader_pkg.sv ----
// types shared by the prom loader modules
package prom_loader_pkg;

  typedef enum logic [1:0] {
    OP_READ  = 2'h1,
    OP_WRITE = 2'h2
  } prom_op_e;

  typedef enum logic [2:0] {
    C_IDLE = 3'h1,
    C_RUN  = 3'h2,
    C_WAIT = 3'h4
  } ctl_state_e;

  typedef enum logic [3:0] {
    E_IDLE  = 4'h1,
    E_SHIFT = 4'h2,
    E_GAP   = 4'h4,
    E_POLL  = 4'h8
  } eng_state_e;

endpackage : prom_loader_pkg

// ---- rtl/prom_cmd_if.sv ----
// word command channel and serial pins between controller and serial engine
`timescale 1ns/1ps
`default_nettype none
interface prom_cmd_if;
  import prom_loader_pkg::*;
  logic        start;
  prom_op_e    op;
  logic [5:0]  addr;
  logic [15:0] wdata;
  logic        done;
  logic [15:0] rdata;
  logic        sdo;
  logic        cs;
  logic        sk;
  logic        di;

  modport ctl (output start, op, addr, wdata, sdo, input done, rdata, cs, sk, di);
  modport eng (input start, op, addr, wdata, sdo, output done, rdata, cs, sk, di);
endinterface : prom_cmd_if
`default_nettype wire

// ---- rtl/prom_serial_engine.sv ----
// three-wire serial prom engine: one word read or one word write per command
`timescale 1ns/1ps
`default_nettype none
`include "prom_loader_map.svh"
module prom_serial_engine
  import prom_loader_pkg::*;
(
  // clock and reset
  input  wire logic core_clk,
  input  wire logic rstn,
  // command channel and pins
  prom_cmd_if.eng   cmd
);

  localparam logic [7:0] HALF = 8'(`SK_HALF_CYC);

  eng_state_e  state_q;
  logic [24:0] tx_q;
  logic [15:0] rx_q;
  logic [4:0]  nbits_q;
  logic [7:0]  cnt_q;
  logic        wen_pend_q;
  logic        poll_pend_q;
  logic        tick;

  assign tick = (cnt_q == HALF - 8'h01);

  // ----------------------------------------------------------------
  // half period timer
  // ----------------------------------------------------------------
  always_ff @(posedge core_clk or negedge rstn) begin
    if (!rstn) begin
      cnt_q <= 8'h00;
    end else if (state_q == E_IDLE || tick) begin
      cnt_q <= 8'h00;
    end else begin
      cnt_q <= cnt_q + 8'h01;
    end
  end

  // ----------------------------------------------------------------
  // frame sequencer
  // ----------------------------------------------------------------
  always_ff @(posedge core_clk or negedge rstn) begin
    if (!rstn) begin
      state_q     <= E_IDLE;
      tx_q        <= 25'h0;
      rx_q        <= 16'h0;
      nbits_q     <= 5'h0;
      wen_pend_q  <= 1'b0;
      poll_pend_q <= 1'b0;
      cmd.cs      <= 1'b0;
      cmd.sk      <= 1'b0;
      cmd.di      <= 1'b0;
      cmd.done    <= 1'b0;
      cmd.rdata   <= 16'h0;
    end else begin
      cmd.done <= 1'b0;
      unique case (state_q)
        E_IDLE: begin
          if (cmd.start) begin
            cmd.cs  <= 1'b1;
            cmd.di  <= 1'b1;
            state_q <= E_SHIFT;
            if (cmd.op == OP_WRITE) begin
              tx_q       <= {`FRAME_WEN, 16'h0}; // RULE15
              nbits_q    <= 5'd9;
              wen_pend_q <= 1'b1;
            end else begin
              tx_q       <= {`FRAME_READ, cmd.addr, 16'h0}; // RULE15
              nbits_q    <= 5'd25;
              wen_pend_q <= 1'b0;
            end
          end
        end
        E_SHIFT: begin
          if (tick) begin
            if (!cmd.sk) begin
              cmd.sk <= 1'b1;
            end else begin
              cmd.sk  <= 1'b0;
              rx_q    <= {rx_q[14:0], cmd.sdo};
              tx_q    <= {tx_q[23:0], 1'b0};
              cmd.di  <= tx_q[23];
              nbits_q <= nbits_q - 5'h1;
              if (nbits_q == 5'h1) begin
                cmd.cs  <= 1'b0;
                cmd.di  <= 1'b0;
                state_q <= E_GAP;
              end
            end
          end
        end
        E_GAP: begin
          if (tick) begin
            if (wen_pend_q) begin
              wen_pend_q  <= 1'b0;
              poll_pend_q <= 1'b1;
              cmd.cs      <= 1'b1;
              cmd.di      <= 1'b1;
              tx_q        <= {`FRAME_WRITE, cmd.addr, cmd.wdata}; // RULE15
              nbits_q     <= 5'd25;
              state_q     <= E_SHIFT;
            end else if (poll_pend_q) begin
              poll_pend_q <= 1'b0;
              cmd.cs      <= 1'b1;
              state_q     <= E_POLL;
            end else begin
              cmd.rdata <= rx_q; // RULE13
              cmd.done  <= 1'b1;
              state_q   <= E_IDLE;
            end
          end
        end
        E_POLL: begin
          if (tick && cmd.sdo) begin // RULE15
            cmd.cs   <= 1'b0;
            cmd.done <= 1'b1;
            state_q  <= E_IDLE;
          end
        end
      endcase
    end
  end

endmodule : prom_serial_engine
`default_nettype wire

// ---- rtl/serial_prom_config_loader.sv ----
// configuration loader: ahb-lite registers, reset load and serial prom jobs
//
// Local design decisions: the placing of the registers and the AHB-Lite interface to the registers.
`timescale 1ns/1ps
`default_nettype none
`include "prom_loader_map.svh"
module serial_prom_config_loader
  import prom_loader_pkg::*;
(
  // clock and reset
  input  wire logic        core_clk,
  input  wire logic        rstn,
  // ahb-lite slave
  input  wire logic        hsel,
  input  wire logic [31:0] haddr,
  input  wire logic [1:0]  htrans,
  input  wire logic        hwrite,
  input  wire logic [2:0]  hsize,
  input  wire logic [31:0] hwdata,
  input  wire logic        hready,
  output logic             hreadyout,
  output logic [31:0]      hrdata,
  output logic             hresp,
  // straps
  input  wire logic        prom_attach_strap,
  input  wire logic [2:0]  slot_select_straps,
  // serial prom pins
  output logic             prom_cs,
  output logic             prom_sk,
  output logic             prom_di,
  input  wire logic        prom_do
);

  prom_cmd_if cmd ();

  prom_serial_engine u_engine (
    .core_clk (core_clk),
    .rstn     (rstn),
    .cmd      (cmd)
  );

  assign prom_cs = cmd.cs;
  assign prom_sk = cmd.sk;
  assign prom_di = cmd.di;
  assign hresp   = 1'b0;

  // ----------------------------------------------------------------
  // pin synchronisers
  // ----------------------------------------------------------------
  logic [4:0] sync1_q;
  logic [4:0] sync2_q;
  logic       attach;
  logic [2:0] slot;

  always_ff @(posedge core_clk or negedge rstn) begin
    if (!rstn) begin
      sync1_q <= 5'h0;
      sync2_q <= 5'h0;
    end else begin
      sync1_q <= {prom_do, prom_attach_strap, slot_select_straps};
      sync2_q <= sync1_q;
    end
  end

  assign cmd.sdo = sync2_q[4];
  assign attach  = sync2_q[3];
  assign slot    = sync2_q[2:0];

  // ----------------------------------------------------------------
  // job controller
  // ----------------------------------------------------------------
  ctl_state_e  state_q;
  logic [1:0]  boot_cnt_q;
  logic        boot_q;
  logic        job_fetch_q;
  logic        job_gp_q;
  logic [2:0]  step_q;
  logic [2:0]  last_q;
  logic        select_q;
  logic [5:0]  pointer_q;
  logic [15:0] scratch_q;
  logic [15:0] setup_q;
  logic [15:0] base_q;
  logic [15:0] station_q [0:2];
  logic        busy;
  logic        req_fetch;
  logic        req_save;
  logic        exec;
  logic [7:0]  dp_addr_q;
  logic        hwrite_q;

  assign busy = boot_q || (state_q != C_IDLE);

  // word address of the current step
  always_comb begin
    if (job_gp_q) begin
      cmd.addr = pointer_q; // RULE1 RULE2
    end else if (step_q < 3'h2) begin
      cmd.addr = {1'b0, slot, 2'b00} | {5'h0, step_q[0]}; // RULE10
    end else begin
      cmd.addr = `STATION_WORD + {3'h0, step_q - 3'h2}; // RULE10
    end
  end

  always_comb begin
    if (job_gp_q) begin
      cmd.wdata = scratch_q;
    end else if (step_q == 3'h0) begin
      cmd.wdata = setup_q;
    end else begin
      cmd.wdata = base_q;
    end
  end

  assign cmd.op = job_fetch_q ? OP_READ : OP_WRITE;

  // requests from a control write, taken only when idle
  assign req_fetch = exec && dp_addr_q == `REG_CONTROL && hwrite_q && !busy
                     && hwdata[`CTL_FETCH_BIT] && attach; // RULE3 RULE7 RULE16
  assign req_save  = exec && dp_addr_q == `REG_CONTROL && hwrite_q && !busy
                     && hwdata[`CTL_SAVE_BIT] && attach; // RULE3 RULE7 RULE16

  always_ff @(posedge core_clk or negedge rstn) begin
    if (!rstn) begin
      state_q     <= C_IDLE;
      boot_q      <= 1'b1;
      boot_cnt_q  <= 2'h0;
      job_fetch_q <= 1'b0;
      job_gp_q    <= 1'b0;
      step_q      <= 3'h0;
      last_q      <= 3'h0;
      cmd.start   <= 1'b0;
    end else begin
      cmd.start <= 1'b0;
      unique case (state_q)
        C_IDLE: begin
          if (boot_q) begin
            boot_cnt_q <= boot_cnt_q + 2'h1;
            if (boot_cnt_q == 2'h3) begin
              job_fetch_q <= 1'b1;
              job_gp_q    <= 1'b0;
              step_q      <= (slot == `SLOT_NONE) ? 3'h2 : 3'h0; // RULE12
              last_q      <= `STATION_LAST;
              state_q     <= attach ? C_RUN : C_IDLE; // RULE6 RULE7 RULE8
              boot_q      <= attach;
            end
          end else if (req_fetch) begin
            job_fetch_q <= 1'b1;
            job_gp_q    <= hwdata[`CTL_SELECT_BIT]; // RULE1 RULE11
            step_q      <= (!hwdata[`CTL_SELECT_BIT] && slot == `SLOT_NONE) ? 3'h2 : 3'h0;
            last_q      <= hwdata[`CTL_SELECT_BIT] ? 3'h0 : `STATION_LAST;
            state_q     <= C_RUN;
          end else if (req_save) begin
            job_fetch_q <= 1'b0;
            job_gp_q    <= hwdata[`CTL_SELECT_BIT]; // RULE2 RULE11
            step_q      <= 3'h0;
            last_q      <= hwdata[`CTL_SELECT_BIT] ? 3'h0 : 3'h1;
            state_q     <= (!hwdata[`CTL_SELECT_BIT] && slot == `SLOT_NONE) ? C_IDLE : C_RUN;
          end
        end
        C_RUN: begin
          cmd.start <= 1'b1;
          state_q   <= C_WAIT;
        end
        C_WAIT: begin
          if (cmd.done) begin
            if (step_q == last_q) begin
              state_q <= C_IDLE; // RULE5
              boot_q  <= 1'b0;
            end else begin
              step_q  <= step_q + 3'h1;
              state_q <= C_RUN;
            end
          end
        end
      endcase
    end
  end

  // ----------------------------------------------------------------
  // ahb-lite data phase, held off while a job runs, except control register accesses
  // ----------------------------------------------------------------
  logic pend_q;

  assign exec = pend_q && !(busy && dp_addr_q != `REG_CONTROL); // RULE5 RULE6

  always_ff @(posedge core_clk or negedge rstn) begin
    if (!rstn) begin
      pend_q    <= 1'b0;
      hwrite_q  <= 1'b0;
      dp_addr_q <= 8'h00;
      hreadyout <= 1'b1;
    end else if (hsel && htrans[1] && hready) begin
      pend_q    <= 1'b1;
      hwrite_q  <= hwrite;
      dp_addr_q <= {haddr[7:2], 2'b00};
      hreadyout <= 1'b0;
    end else if (exec) begin
      pend_q    <= 1'b0;
      hreadyout <= 1'b1;
    end
  end

  // read data
  always_ff @(posedge core_clk or negedge rstn) begin
    if (!rstn) begin
      hrdata <= 32'h0;
    end else if (exec && !hwrite_q) begin
      unique case (dp_addr_q)
        `REG_CONTROL:  hrdata <= {29'h0, busy, busy, select_q}; // RULE4 RULE14
        `REG_POINTER:  hrdata <= {26'h0, pointer_q};
        `REG_SCRATCH:  hrdata <= {16'h0, scratch_q};
        `REG_SETUP:    hrdata <= {16'h0, setup_q};
        `REG_BASE:     hrdata <= {16'h0, base_q};
        `REG_STATION0: hrdata <= {16'h0, station_q[0]};
        `REG_STATION1: hrdata <= {16'h0, station_q[1]};
        `REG_STATION2: hrdata <= {16'h0, station_q[2]};
        `REG_STATUS:   hrdata <= {27'h0, busy, attach, slot};
        default:       hrdata <= 32'h0;
      endcase
    end
  end

  // ----------------------------------------------------------------
  // register storage: software writes and prom loads
  // ----------------------------------------------------------------
  always_ff @(posedge core_clk or negedge rstn) begin
    if (!rstn) begin
      select_q  <= 1'b0;
      pointer_q <= 6'h00;
      scratch_q <= 16'h0000;
      setup_q   <= `SETUP_RST; // RULE8
      base_q    <= `BASE_RST;
      for (int i = 0; i < 3; i++) begin
        station_q[i] <= `STATION_RST;
      end
    end else if (state_q == C_WAIT && cmd.done && job_fetch_q) begin
      if (job_gp_q) begin
        scratch_q <= cmd.rdata; // RULE1
      end else if (step_q == 3'h0) begin
        setup_q <= cmd.rdata; // RULE11
      end else if (step_q == 3'h1) begin
        base_q <= cmd.rdata;
      end else begin
        station_q[step_q[1:0] ^ 2'h2] <= cmd.rdata;
      end
    end else if (exec && hwrite_q) begin
      unique case (dp_addr_q)
        `REG_CONTROL:  if (!busy) select_q <= hwdata[`CTL_SELECT_BIT]; // RULE16
        `REG_POINTER:  pointer_q <= hwdata[5:0];
        `REG_SCRATCH:  scratch_q <= hwdata[15:0];
        `REG_SETUP:    setup_q <= hwdata[15:0]; // RULE9
        `REG_BASE:     base_q <= hwdata[15:0];
        `REG_STATION0: station_q[0] <= hwdata[15:0];
        `REG_STATION1: station_q[1] <= hwdata[15:0];
        `REG_STATION2: station_q[2] <= hwdata[15:0];
        default:       ;
      endcase
    end
  end

endmodule : serial_prom_config_loader
`default_nettype wire

// ---- bench/prom_loader_sva.sv ----
// port assertions for the serial prom configuration loader
`timescale 1ns/1ps
`default_nettype none
module prom_loader_sva (
  // bus
  input wire logic        core_clk,
  input wire logic        rstn,
  input wire logic        hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0]  htrans,
  input wire logic        hwrite,
  input wire logic        hready,
  input wire logic        hreadyout,
  input wire logic [31:0] hrdata,
  // strap and prom pins
  input wire logic        prom_attach_strap,
  input wire logic        prom_cs,
  input wire logic        prom_sk,
  input wire logic        prom_di
);
  default clocking @(posedge core_clk); endclocking
  default disable iff (!rstn);
  wire logic tk = hsel && htrans[1] && hready;
  wire logic ctl = (haddr[7:2] == 6'h00);
  sequence stall2;
    !hreadyout ##1 !hreadyout;
  endsequence
  sequence ctl_done;
    !hreadyout ##1 hreadyout;
  endsequence
  a_ready_drop: assert property (tk |=> !hreadyout)
    else $error("no wait state after address phase");
  a_ctrl_two_cyc: assert property (tk && ctl |=> ctl_done)
    else $error("control access not two cycles");
  a_busy_ctrl_read: assert property (tk && ctl && !hwrite && prom_sk |=> ##1 hrdata[2:1] == 2'b11)
    else $error("busy not shown on control read");
  a_busy_blocks: assert property (tk && !ctl && prom_sk |=> stall2)
    else $error("access not held off during prom job");
  a_no_prom_cs: assert property (!prom_attach_strap [*3] |-> !prom_cs)
    else $error("prom selected with strap low");
  a_sk_in_frame: assert property ($rose(prom_sk) |-> prom_cs)
    else $error("serial clock outside frame");
  a_di_steady: assert property (prom_sk && $past(prom_sk) |-> $stable(prom_di))
    else $error("data changed while clock high");
  a_sk_half: assert property ($rose(prom_sk) |-> ##100 $fell(prom_sk))
    else $error("serial clock high time wrong");
  a_upper_zero: assert property (hrdata[31:16] == 16'h0000)
    else $error("read data upper half not zero");
endmodule : prom_loader_sva
bind serial_prom_config_loader prom_loader_sva prom_loader_sva_i (.core_clk(core_clk),
  .rstn(rstn), .hsel(hsel), .haddr(haddr), .htrans(htrans), .hwrite(hwrite),
  .hready(hready), .hreadyout(hreadyout), .hrdata(hrdata),
  .prom_attach_strap(prom_attach_strap), .prom_cs(prom_cs), .prom_sk(prom_sk),
  .prom_di(prom_di));
`default_nettype wire

// ---- bench/prom_model.sv ----
// behavioural three-wire serial prom of 64 words by 16 bits
`timescale 1ns/1ps
`default_nettype none
module prom_model #(
  parameter int WR_NS = 3000
) (
  // serial pins
  input  wire logic cs,
  input  wire logic sk,
  input  wire logic di,
  output var logic  do_o
);
  logic [15:0] mem [64];
  logic [24:0] sh;
  logic [5:0]  ra;
  logic        rdm;
  logic        wen;
  logic        busy;
  int          cnt;
  initial begin
    cnt = 0;
    wen = 1'b0;
    busy = 1'b0;
    rdm = 1'b0;
    do_o = 1'b0;
  end
  // command bits shift in; read data leaves from the tenth clock
  always @(posedge sk) begin
    if (cs) begin
      sh = {sh[23:0], di};
      cnt = cnt + 1;
      if (cnt == 9) begin
        rdm = (sh[8:6] == 3'b110);
        ra = sh[5:0];
      end
      if (cnt >= 10 && rdm) do_o = mem[ra][25-cnt];
    end
  end
  // frame end: write enable, word commit, busy time; released line flips
  always @(negedge cs) begin
    if (cnt == 9 && sh[8:0] == 9'h130) wen = 1'b1;
    if (cnt == 25 && sh[24:22] == 3'b101 && wen) begin
      mem[sh[21:16]] = sh[15:0];
      busy = 1'b1;
      busy <= #(WR_NS) 1'b0;
    end
    rdm = 1'b0;
    cnt = 0;
    do_o = ~do_o;
  end
  always @(posedge cs or busy) if (cs && cnt == 0) do_o = ~busy;
endmodule : prom_model
`default_nettype wire

// ---- bench/serial_prom_config_loader_tb_top.sv ----
// self-checking bench for the serial prom configuration loader
`timescale 1ns/1ps
`default_nettype none
`include "prom_loader_map.svh"
module serial_prom_config_loader_tb_top;
  logic        core_clk, rstn, hsel, hwrite, attach;
  logic [31:0] haddr, hwdata, rd;
  logic [1:0]  htrans;
  logic [2:0]  slot;
  wire logic [31:0] hrdata;
  wire logic   hreadyout, hresp, cs, sk, di, pdo;
  int          n_errors, cmp_count, cyc;

  serial_prom_config_loader serial_prom_config_loader_i (.core_clk(core_clk), .rstn(rstn),
    .hsel(hsel), .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(3'h2),
    .hwdata(hwdata), .hready(hreadyout), .hreadyout(hreadyout), .hrdata(hrdata),
    .hresp(hresp), .prom_attach_strap(attach), .slot_select_straps(slot),
    .prom_cs(cs), .prom_sk(sk), .prom_di(di), .prom_do(pdo));
  prom_model #(.WR_NS(3000)) prom_model_i (.cs(cs), .sk(sk), .di(di), .do_o(pdo));

  initial begin
    core_clk = 1'b0;
    forever #2.5 core_clk = ~core_clk;
  end
  always @(posedge core_clk) begin
    cyc = cyc + 1;
    if (cyc == 95000) begin
      n_errors = n_errors + 1;
      results();
    end
  end

  function automatic logic [15:0] pw(input int i);
    return 16'h5A00 + 16'(i) * 16'h0103;
  endfunction : pw
  task automatic check(input string nm, input logic [31:0] exp, input logic [31:0] seen);
    cmp_count = cmp_count + 1;
    if (seen !== exp) begin
      n_errors = n_errors + 1;
      $display("[FAIL] %s expected %h seen %h", nm, exp, seen);
    end
  endtask : check
  task automatic ahb(input logic wr, input logic [7:0] a, input logic [31:0] d);
    @(posedge core_clk);
    hsel <= 1'b1;
    htrans <= 2'h2;
    haddr <= {24'h000000, a};
    hwrite <= wr;
    do @(posedge core_clk); while (hreadyout !== 1'b1);
    hsel <= 1'b0;
    htrans <= 2'h0;
    hwdata <= d;
    do @(posedge core_clk); while (hreadyout !== 1'b1);
    rd = hrdata;
  endtask : ahb
  task automatic rd_chk(input string nm, input logic [7:0] a, input logic [31:0] exp);
    ahb(1'b0, a, 32'h0);
    check(nm, exp, rd);
  endtask : rd_chk
  task automatic poll;
    do ahb(1'b0, `REG_CONTROL, 32'h0); while (rd[2:1] !== 2'b00);
  endtask : poll
  task automatic boot(input logic at, input logic [2:0] s);
    @(posedge core_clk);
    rstn <= 1'b0;
    attach <= at;
    slot <= s;
    repeat (4) @(posedge core_clk);
    rstn <= 1'b1;
  endtask : boot

  task automatic t_boot;
    boot(1'b1, 3'h6);
    rd_chk("busy control", `REG_CONTROL, 32'h6);
    check("okay response", 32'h0, {31'h0, hresp});
    rd_chk("setup", `REG_SETUP, pw(24));
    rd_chk("base", `REG_BASE, pw(25));
    for (int i = 0; i < 3; i++) rd_chk("station", `REG_STATION0 + 8'(4*i), pw(32+i));
    rd_chk("idle control", `REG_CONTROL, 32'h0);
    rd_chk("unmapped", 8'h24, 32'h0);
    $display("boot load test done");
  endtask : t_boot
  task automatic t_gp;
    ahb(1'b1, `REG_POINTER, 32'h3F);
    ahb(1'b1, `REG_SCRATCH, 32'hC3A5);
    ahb(1'b1, `REG_CONTROL, 32'h5);
    ahb(1'b1, `REG_CONTROL, 32'h2);
    poll();
    check("saved word", 32'hC3A5, prom_model_i.mem[63]);
    check("prom ready", 32'h0, {31'h0, prom_model_i.busy});
    rd_chk("select kept", `REG_CONTROL, 32'h1);
    ahb(1'b1, `REG_SCRATCH, 32'h0);
    ahb(1'b1, `REG_CONTROL, 32'h3);
    wait (sk === 1'b1);
    rd_chk("fetched word", `REG_SCRATCH, 32'hC3A5);
    $display("pointer access test done");
  endtask : t_gp
  task automatic t_save;
    ahb(1'b1, `REG_CONTROL, 32'h0);
    ahb(1'b1, `REG_SETUP, 32'h1234);
    ahb(1'b1, `REG_BASE, 32'h5678);
    ahb(1'b1, `REG_CONTROL, 32'h4);
    poll();
    check("setup word", 32'h1234, prom_model_i.mem[24]);
    check("base word", 32'h5678, prom_model_i.mem[25]);
    check("pointer word", 32'hC3A5, prom_model_i.mem[63]);
    $display("normal save test done");
  endtask : t_save
  task automatic t_slot7;
    boot(1'b1, 3'h7);
    poll();
    rd_chk("setup default", `REG_SETUP, 32'h0);
    rd_chk("station only", `REG_STATION2, pw(34));
    ahb(1'b1, `REG_STATION2, 32'h0);
    ahb(1'b1, `REG_SETUP, 32'h1111);
    ahb(1'b1, `REG_CONTROL, 32'h2);
    poll();
    rd_chk("station reload", `REG_STATION2, pw(34));
    rd_chk("setup kept", `REG_SETUP, 32'h1111);
    ahb(1'b1, `REG_CONTROL, 32'h4);
    poll();
    check("no save", pw(28), prom_model_i.mem[28]);
    $display("no slot test done");
  endtask : t_slot7
  task automatic t_noprom;
    boot(1'b0, 3'h2);
    poll();
    ahb(1'b1, `REG_CONTROL, 32'h2);
    rd_chk("no job", `REG_CONTROL, 32'h0);
    rd_chk("base default", `REG_BASE, 32'h0);
    rd_chk("station default", `REG_STATION1, 32'h0);
    ahb(1'b1, `REG_SETUP, 32'hBEEF);
    rd_chk("setup by host", `REG_SETUP, 32'hBEEF);
    rd_chk("status", `REG_STATUS, 32'h2);
    $display("no prom test done");
  endtask : t_noprom

  task automatic results;
    $display("comparisons %0d mismatches %0d", cmp_count, n_errors);
    if (n_errors == 0 && cmp_count > 0) $display("TEST PASSED");
    else $display("TEST FAILED");
    $finish;
  endtask : results

  initial begin
    rstn = 1'b0;
    hsel = 1'b0;
    haddr = 32'h0;
    htrans = 2'h0;
    hwrite = 1'b0;
    hwdata = 32'h0;
    attach = 1'b1;
    slot = 3'h6;
    n_errors = 0;
    cmp_count = 0;
    cyc = 0;
    for (int i = 0; i < 64; i++) prom_model_i.mem[i] = pw(i);
    t_boot();
    t_gp();
    t_save();
    t_slot7();
    t_noprom();
    results();
  end
endmodule : serial_prom_config_loader_tb_top
`default_nettype wire
